// *** lsf_pkg.sv ***
// constants and types for the line status flag block
package lsf_pkg;

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W           = 3;
  localparam logic [2:0]  TX_DATA_ADDR     = 3'h0;
  localparam logic [2:0]  CONTROL_ADDR     = 3'h1;
  localparam logic [2:0]  LINE_STATUS_ADDR = 3'h5;
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  READ_ZERO        = 8'h00;

  // ==========================================================
  // control fields
  localparam int unsigned CTRL_QUEUED_BIT = 0;
  localparam int unsigned CTRL_TXIE_BIT   = 1;

  // ==========================================================
  // line status fields
  localparam int unsigned LS_ERR_BIT     = 7;
  localparam int unsigned LS_TEMT_BIT    = 6;
  localparam int unsigned LS_THRE_BIT    = 5;
  localparam int unsigned LS_BREAK_BIT   = 4;
  localparam int unsigned LS_FRAME_BIT   = 3;
  localparam int unsigned LS_PARITY_BIT  = 2;
  localparam int unsigned LS_OVERRUN_BIT = 1;
  localparam int unsigned LS_READY_BIT   = 0;

  // ==========================================================
  // queue and timing
  localparam int unsigned QUEUE_DEPTH = 32;
  localparam int unsigned PTR_W       = 5;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned FRAME_W     = 16;
  localparam int unsigned ERR_W       = 3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } lsf_bus_req_t;

  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
  } lsf_rx_err_t;

  typedef struct packed {
    logic [7:0]         ctrl;
    logic               hold_full;
    logic               tx_wr;
    logic [7:0]         tx_data;
    logic               rx_sync1;
    logic               rx_sync2;
    logic [FRAME_W-1:0] low_cnt;
    logic               brk_armed;
    logic               brk_push;
    logic               brk_flag;
    logic               frame_flag;
    logic               parity_flag;
    logic               overrun_flag;
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic [CNT_W-1:0]   count;
    logic [CNT_W-1:0]   err_count;
    logic [7:0]         rdata;
  } lsf_state_t;

endpackage

// *** lsf_err_mem.sv ***
// error tag memory that mirrors the receive queue
`timescale 1ns/1ps
`default_nettype none
module lsf_err_mem
  import lsf_pkg::*;
#(
  parameter int unsigned DEPTH = QUEUE_DEPTH,
  parameter int unsigned AW    = PTR_W
) (
  input  wire logic            clk_sys,
  input  wire logic            we,
  input  wire logic [AW-1:0]   waddr,
  input  wire lsf_rx_err_t     wdata,
  input  wire logic [AW-1:0]   raddr,
  output var lsf_rx_err_t      rdata
);

  // ==========================================================
  // storage
  lsf_rx_err_t mem [DEPTH];

  // ==========================================================
  // write first so a fresh head is seen at once
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // lsf_err_mem
`default_nettype wire

// *** lsf_line_status.sv ***
// line status flags for one serial channel
// Notes on behaviour
// - error flag is set while any queued character has parity, framing or break
// - error flag clears only when no queued character carries an error
// - non-queued: transmit empty when holding stage and shifter both empty
// - transmit empty is 0 while holding stage or shifter holds a character
// - queued: transmit empty when transmit queue and shifter both empty
// - non-queued: holding empty sets when character moves into the shifter
// - non-queued: holding empty clears on the host write to the holding stage
// - interrupt request while holding empty and its enable is on
// - queued: holding empty while transmit queue empty, clears on a write
// - break flag sets after receive line low for one full frame time
// - queued: one break character loaded per break condition
// - error flag and break flag read 0 after reset
// - framing error flagged, tied to queue head in queued mode
// - parity error flagged, tied to queue head in queued mode
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lsf_line_status
  import lsf_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire lsf_bus_req_t       bus_req,
  output logic [7:0]              bus_rdata,
  output logic                    tx_wr,
  output logic [7:0]              tx_data,
  input  wire logic               tsr_load,
  input  wire logic               tsr_empty,
  input  wire logic               tx_queue_empty,
  input  wire logic               rx_serial,
  input  wire logic [FRAME_W-1:0] frame_cycles,
  input  wire logic               rx_push,
  input  wire lsf_rx_err_t        rx_push_err,
  input  wire logic               rx_pop,
  input  wire logic               rx_overrun,
  output logic                    brk_push,
  output logic                    queued_mode,
  output logic [7:0]              line_status,
  output logic                    irq
);

  // ==========================================================
  // reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // state and head tag
  lsf_state_t  st;
  lsf_state_t  next_st;
  lsf_rx_err_t head_err;
  logic [PTR_W-1:0] next_rd_ptr;
  logic        push_ok;
  logic        pop_ok;
  logic        push_bad;
  logic        pop_bad;
  logic        ls_read;
  logic        hold_wr;
  logic        thre;
  logic        temt;
  logic        brk_hit;

  lsf_err_mem #(
    .DEPTH (QUEUE_DEPTH),
    .AW    (PTR_W)
  ) u_err_mem (
    .clk_sys (clk_sys),
    .we      (push_ok),
    .waddr   (st.wr_ptr),
    .wdata   (rx_push_err),
    .raddr   (next_rd_ptr),
    .rdata   (head_err)
  );

  // ==========================================================
  // flag views
  always_comb begin
    queued_mode = st.ctrl[CTRL_QUEUED_BIT];
    push_ok     = rx_push && (st.count != CNT_W'(QUEUE_DEPTH));
    pop_ok      = rx_pop && (st.count != '0);
    push_bad    = push_ok && (|rx_push_err);
    pop_bad     = pop_ok && (|head_err);
    ls_read     = bus_req.rd && (bus_req.addr == LINE_STATUS_ADDR);
    hold_wr     = bus_req.wr && (bus_req.addr == TX_DATA_ADDR);
    next_rd_ptr = pop_ok ? PTR_W'(st.rd_ptr + 1'b1) : st.rd_ptr;
    if (queued_mode) begin
      thre = tx_queue_empty && !st.tx_wr;
      temt = tx_queue_empty && !st.tx_wr && tsr_empty;
    end else begin
      thre = !st.hold_full;
      temt = !st.hold_full && tsr_empty;
    end
    line_status                 = READ_ZERO;
    line_status[LS_ERR_BIT]     = (st.err_count != '0);
    line_status[LS_TEMT_BIT]    = temt;
    line_status[LS_THRE_BIT]    = thre;
    line_status[LS_BREAK_BIT]   = st.brk_flag;
    line_status[LS_OVERRUN_BIT] = st.overrun_flag;
    line_status[LS_READY_BIT]   = (st.count != '0);
    if (queued_mode) begin
      line_status[LS_FRAME_BIT]  = (st.count != '0) && head_err.framing;
      line_status[LS_PARITY_BIT] = (st.count != '0) && head_err.parity;
    end else begin
      line_status[LS_FRAME_BIT]  = st.frame_flag;
      line_status[LS_PARITY_BIT] = st.parity_flag;
    end
    irq = thre && st.ctrl[CTRL_TXIE_BIT];
    brk_hit = st.rx_sync2 == 1'b0 && st.brk_armed &&
              (st.low_cnt >= frame_cycles) && (frame_cycles != '0);
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st          = st;
    next_st.tx_wr    = 1'b0;
    next_st.brk_push = 1'b0;
    next_st.rx_sync1 = rx_serial;
    next_st.rx_sync2 = st.rx_sync1;
    // bus writes; line status writes fall through untouched
    if (bus_req.wr && bus_req.addr == CONTROL_ADDR) begin
      next_st.ctrl = bus_req.wdata;
    end
    if (hold_wr) begin
      next_st.tx_data = bus_req.wdata;
      next_st.tx_wr   = 1'b1;
    end
    // holding stage: a host write beats a move in the same cycle
    if (tsr_load) begin
      next_st.hold_full = 1'b0;
    end
    if (hold_wr) begin
      next_st.hold_full = 1'b1;
    end
    // bus reads
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        LINE_STATUS_ADDR: next_st.rdata = line_status;
        CONTROL_ADDR:     next_st.rdata = st.ctrl;
        default:          next_st.rdata = READ_ZERO;
      endcase
    end
    // break detection on the synchronised line
    if (st.rx_sync2) begin
      next_st.low_cnt   = '0;
      next_st.brk_armed = 1'b1;
    end else if (st.low_cnt != '1) begin
      next_st.low_cnt = FRAME_W'(st.low_cnt + 1'b1);
    end
    // sticky flags cleared by a status read; a set wins
    if (ls_read) begin
      next_st.brk_flag     = 1'b0;
      next_st.frame_flag   = 1'b0;
      next_st.parity_flag  = 1'b0;
      next_st.overrun_flag = 1'b0;
    end
    if (brk_hit) begin
      next_st.brk_flag  = 1'b1;
      next_st.brk_armed = 1'b0;
      next_st.brk_push  = queued_mode;
    end
    if (push_ok && rx_push_err.framing) begin
      next_st.frame_flag = 1'b1;
    end
    if (push_ok && rx_push_err.parity) begin
      next_st.parity_flag = 1'b1;
    end
    if (rx_overrun) begin
      next_st.overrun_flag = 1'b1;
    end
    // receive queue mirror
    if (push_ok) begin
      next_st.wr_ptr = PTR_W'(st.wr_ptr + 1'b1);
    end
    next_st.rd_ptr = next_rd_ptr;
    unique case ({push_ok, pop_ok})
      2'b10:   next_st.count = CNT_W'(st.count + 1'b1);
      2'b01:   next_st.count = CNT_W'(st.count - 1'b1);
      default: next_st.count = st.count;
    endcase
    unique case ({push_bad, pop_bad})
      2'b10:   next_st.err_count = CNT_W'(st.err_count + 1'b1);
      2'b01:   next_st.err_count = CNT_W'(st.err_count - 1'b1);
      default: next_st.err_count = st.err_count;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st           <= '0;
      st.ctrl      <= CONTROL_RESET;
      st.rx_sync1  <= 1'b1;
      st.rx_sync2  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    bus_rdata = st.rdata;
    tx_wr     = st.tx_wr;
    tx_data   = st.tx_data;
    brk_push  = st.brk_push;
  end

  // ==========================================================
  // assertions
  a_err_on_bad_push: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    push_bad && !pop_ok |=> line_status[LS_ERR_BIT])
    else $error("error flag missing after bad push");

  a_err_clear_empty: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (st.count == '0) |-> !line_status[LS_ERR_BIT])
    else $error("error flag set with empty queue");

  a_temt_plain: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    !queued_mode && !st.hold_full && tsr_empty |-> line_status[LS_TEMT_BIT])
    else $error("transmit empty not shown");

  a_temt_busy: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    !tsr_empty || (!queued_mode && st.hold_full) |->
      !line_status[LS_TEMT_BIT])
    else $error("transmit empty while busy");

  a_temt_queued: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    queued_mode && tx_queue_empty && !st.tx_wr && tsr_empty |->
      line_status[LS_TEMT_BIT])
    else $error("queued transmit empty not shown");

  a_thre_on_move: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    !queued_mode && tsr_load && !hold_wr && $stable(queued_mode) ##1
      !queued_mode |-> line_status[LS_THRE_BIT])
    else $error("holding empty not set after move");

  a_thre_on_write: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    hold_wr ##1 !queued_mode |-> !line_status[LS_THRE_BIT])
    else $error("holding empty not cleared by write");

  a_irq_follows: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    irq == (line_status[LS_THRE_BIT] && st.ctrl[CTRL_TXIE_BIT]))
    else $error("interrupt request mismatch");

  a_thre_queued: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    queued_mode && hold_wr ##1 queued_mode |-> !line_status[LS_THRE_BIT])
    else $error("queued holding empty not cleared");

  a_break_sets: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    brk_hit |=> line_status[LS_BREAK_BIT])
    else $error("break flag not set");

  a_break_once: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    brk_hit |=> (!brk_hit until st.rx_sync2))
    else $error("second break character in one condition");

  a_reset_flags: assert property (
    @(posedge clk_sys)
    $rose(rst_sync_n) |-> !line_status[LS_ERR_BIT] &&
      !line_status[LS_BREAK_BIT])
    else $error("flags not clear after reset");

  a_frame_head: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    queued_mode && st.count == '0 |-> !line_status[LS_FRAME_BIT])
    else $error("framing flag without a head character");

  a_parity_latch: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    !queued_mode && push_ok && rx_push_err.parity ##1 !queued_mode |->
      line_status[LS_PARITY_BIT])
    else $error("parity flag not latched");

  a_status_ro: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    bus_req.wr && bus_req.addr == LINE_STATUS_ADDR |=>
      st.ctrl == $past(st.ctrl))
    else $error("status write changed control");

  c_break_seen: cover property (
    @(posedge clk_sys) disable iff (!rst_sync_n) brk_hit);
  c_err_flag: cover property (
    @(posedge clk_sys) disable iff (!rst_sync_n) $rose(line_status[LS_ERR_BIT]));
  c_queue_full: cover property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    st.count == CNT_W'(QUEUE_DEPTH));
  c_irq_raise: cover property (
    @(posedge clk_sys) disable iff (!rst_sync_n) $rose(irq));

endmodule // lsf_line_status
`default_nettype wire

// *** lsf_tx_model.sv ***
// transmitter stand-in: holding stage or queue feeding a shift register
`timescale 1ns/1ps
`default_nettype none
module lsf_tx_model
  import lsf_pkg::*;
#(
  parameter int unsigned SHIFT_CYC = 20
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic tx_wr,
  output logic      tsr_load,
  output logic      tsr_empty,
  output logic      tx_queue_empty
);
  // ==========================================================
  // pending characters and shifter occupancy
  int pend;
  int busy;
  assign tsr_empty      = (busy == 0);
  assign tx_queue_empty = (pend == 0);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend     <= 0;
      busy     <= 0;
      tsr_load <= 1'b0;
    end else if (pend > 0 && busy == 0 && !tsr_load) begin
      tsr_load <= 1'b1;
      pend     <= pend - 1 + int'(tx_wr);
      busy     <= SHIFT_CYC;
    end else begin
      tsr_load <= 1'b0;
      pend     <= pend + int'(tx_wr);
      busy     <= (busy > 0) ? busy - 1 : 0;
    end
  end
endmodule // lsf_tx_model
`default_nettype wire

// *** uart_line_status_flags_tb.sv ***
// self-checking bench for the line status flag block
`timescale 1ns/1ps
`default_nettype none
module uart_line_status_flags_tb
  import lsf_pkg::*;
;
  localparam int SHIFT = 20;
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  lsf_bus_req_t bus_req = '0;
  logic [7:0]   bus_rdata, tx_data, line_status;
  logic         tx_wr, tsr_load, tsr_empty, tx_queue_empty;
  logic         rx_serial = 1'b1;
  logic [15:0]  frame_cycles = 16'h000A;
  logic         rx_push = 1'b0;
  lsf_rx_err_t  rx_push_err = '0;
  logic         rx_pop = 1'b0;
  logic         rx_overrun = 1'b0;
  logic         brk_push, queued_mode, irq;
  logic [7:0]   rd_val;
  int           failures = 0;
  int           comparisons = 0;
  int           brk_seen = 0;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (brk_push === 1'b1) brk_seen++;

  lsf_line_status dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .tx_wr(tx_wr),
    .tx_data(tx_data), .tsr_load(tsr_load), .tsr_empty(tsr_empty),
    .tx_queue_empty(tx_queue_empty), .rx_serial(rx_serial),
    .frame_cycles(frame_cycles), .rx_push(rx_push),
    .rx_push_err(rx_push_err), .rx_pop(rx_pop), .rx_overrun(rx_overrun),
    .brk_push(brk_push), .queued_mode(queued_mode),
    .line_status(line_status), .irq(irq));

  lsf_tx_model #(.SHIFT_CYC(SHIFT)) tx_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .tx_wr(tx_wr), .tsr_load(tsr_load), .tsr_empty(tsr_empty),
    .tx_queue_empty(tx_queue_empty));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [2:0] a);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    rd_val = bus_rdata;
  endtask

  task automatic rx_op(input logic push, input lsf_rx_err_t e);
    @(posedge clk_sys);
    rx_push     <= push;
    rx_pop      <= !push;
    rx_push_err <= e;
    @(posedge clk_sys);
    rx_push <= 1'b0;
    rx_pop  <= 1'b0;
    tick(1);
  endtask

  task automatic wait_load;
    for (int i = 0; i < 200 && tsr_load !== 1'b1; i++) tick(1);
    tick(1);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    check(line_status, 8'h60, "status after reset");
    bus_rd(LINE_STATUS_ADDR);
    check(rd_val, 8'h60, "status read after reset");
  endtask

  task automatic t_plain_tx;
    bus_wr(CONTROL_ADDR, 8'h02);
    tick(1);
    check({7'h00, irq}, 8'h01, "irq with holding empty");
    bus_wr(TX_DATA_ADDR, 8'hA5);
    check(tx_data, 8'hA5, "holding stage data");
    check({7'h00, tx_wr}, 8'h01, "holding write pulse");
    check({7'h00, line_status[5]}, 8'h00, "holding empty on write");
    check({7'h00, irq}, 8'h00, "irq after write");
    tick(1);
    check({7'h00, line_status[6]}, 8'h00, "tx empty while full");
    wait_load();
    check({7'h00, line_status[5]}, 8'h01, "holding empty on load");
    check({7'h00, line_status[6]}, 8'h00, "tx empty while shifting");
    tick(SHIFT + 3);
    check({7'h00, line_status[6]}, 8'h01, "tx empty when idle");
  endtask

  task automatic t_queued_tx;
    bus_wr(CONTROL_ADDR, 8'h01);
    check({7'h00, queued_mode}, 8'h01, "queued mode set");
    bus_wr(TX_DATA_ADDR, 8'h11);
    check({7'h00, line_status[5]}, 8'h00, "queue not empty");
    bus_wr(TX_DATA_ADDR, 8'h22);
    bus_wr(TX_DATA_ADDR, 8'h33);
    check({7'h00, line_status[6]}, 8'h00, "queued tx busy");
    tick(4 * SHIFT + 10);
    check(line_status[6:5], 8'h03, "queue and shifter empty");
  endtask

  task automatic t_read_only;
    bus_wr(LINE_STATUS_ADDR, 8'h9F);
    bus_rd(LINE_STATUS_ADDR);
    check(rd_val, 8'h60, "status write ignored");
    bus_rd(3'h7);
    check(rd_val, READ_ZERO, "unmapped read");
  endtask

  task automatic t_rx_err;
    rx_op(1'b1, 3'b010);
    rx_op(1'b1, 3'b001);
    rx_op(1'b1, 3'b000);
    check(line_status[7:2], 6'h3A, "frame at head");
    rx_op(1'b0, 3'b000);
    check(line_status[7:2], 6'h39, "parity at head");
    rx_op(1'b0, 3'b000);
    check(line_status[7:2], 6'h18, "clean head left");
    rx_op(1'b0, 3'b000);
  endtask

  task automatic t_rx_plain;
    bus_wr(CONTROL_ADDR, 8'h00);
    bus_rd(LINE_STATUS_ADDR);
    check(rd_val, 8'h7C, "sticky flags before read");
    rx_op(1'b1, 3'b001);
    check(line_status[7:2], 6'h39, "parity latched");
    bus_rd(LINE_STATUS_ADDR);
    check(rd_val, 8'hE5, "status with parity");
    check(line_status[7:2], 6'h38, "parity cleared by read");
    rx_op(1'b0, 3'b000);
    check(line_status[7:2], 6'h18, "error gone with char");
  endtask

  task automatic t_break;
    brk_seen = 0;
    @(posedge clk_sys);
    rx_serial <= 1'b0;
    tick(4 * 10);
    check({7'h00, line_status[4]}, 8'h01, "break seen");
    @(posedge clk_sys);
    rx_serial <= 1'b1;
    tick(10);
    check(8'(brk_seen), 8'h01, "one break char");
  endtask

  task automatic finish_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(3);
    t_reset();
    t_plain_tx();
    t_read_only();
    t_queued_tx();
    t_rx_err();
    t_break();
    t_rx_plain();
    finish_test();
  end

  initial begin
    #(20000 * 5);
    failures++;
    finish_test();
  end
endmodule // uart_line_status_flags_tb
`default_nettype wire
